/* File: verilog/pcs_pkg.sv */
// constants shared by the synthesizer calibration sequencer
package pcs_pkg;
   // register word indices (printed offsets not multiples of four)
   localparam logic [3:0] REG_INT_IDX   = 4'h0;
   localparam logic [3:0] REG_PRIMARY_FRACTION_IDX = 4'h1;
   localparam logic [3:0] REG_AUX_IDX   = 4'h2;
   localparam logic [3:0] REG_REF_IDX   = 4'h3;
   localparam logic [3:0] REG_CAL_IDX   = 4'h4;
   localparam logic [3:0] REG_STAT_IDX  = 4'h5;
   localparam logic [3:0] REG_RATIO_IDX = 4'h6;
   // register address width
   localparam int ADDR_W = 8;
   // primary modulus exponent, fixed
   localparam int PRIMARY_MOD_LOG2 = 24;
   // integer word fields
   localparam int INT_W        = 16;
   localparam int AUTOCAL_BIT  = 21;
   // auxiliary word: fraction low half, modulus high half
   localparam int AUX_W        = 14;
   localparam int AUX_FRAC_LSB = 0;
   localparam int AUX_MOD_LSB  = 16;
   // reference word fields
   localparam int REFDIV_W   = 10;
   localparam int DOUBLE_BIT = 16;
   localparam int HALVE_BIT  = 17;
   // calibration word fields
   localparam int BAND_DIV_LSB = 24;
   localparam int BAND_DIV_W   = 8;
   localparam int TIMEOUT_LSB  = 14;
   localparam int TIMEOUT_W    = 10;
   localparam int LEVEL_LSB    = 9;
   localparam int SETTLE_LSB   = 4;
   localparam int WAIT5_W      = 5;
   // fixed multipliers of the phases
   localparam int BAND_PRESCALE = 16;
   localparam int BAND_PERIODS  = 11;
   localparam int LEVEL_MULT    = 55;
   // reset values
   localparam logic [31:0] CAL_RESET = 32'h0000_0000;
   localparam logic [REFDIV_W-1:0] REFDIV_RESET = 10'h001;
   localparam logic [AUX_W-1:0] AUX_MOD_RESET = 14'h0001;
   // calibration phases
   typedef enum logic [2:0] {
      PCS_IDLE, PCS_SETTLE, PCS_BAND, PCS_LEVEL, PCS_LOCKED
   } pcs_phase_t;
endpackage : pcs_pkg

/* File: verilog/pcs_top.sv */
// calibration sequencer: divider settings, comparison clock, phase timing
//
// What this block does
// R1: feedback ratio is integer plus (fraction plus aux fraction/aux mod) over 2^24; the ratio read gives integer and upper 16 fraction bits only, no aux terms.
// R2: comparison rate is reference times (1+double) over divider times (1+halve).
// R3: the halve stage is a toggle so its output has a 50% duty cycle.
// R4: every calibration counter advances only on comparison clock enables.
// R5: phase one waits timeout times settle-count comparison cycles.
// R6: band selection starts only after the settle count expires.
// R7: band clock is the comparison clock over 16 times the band divider.
// R8: band selection lasts exactly 11 band clock periods.
// R9: level calibration lasts 55 times level-wait times timeout cycles.
// R10: level-wait and settle-count fields are five bits wide.
// R11: the host sets level-wait near 2.5 times settle-count.
// R12: total calibration time is the sum of the three phase times.
// R13: band divider sits in calibration word bits 31 to 24.
// R14: timeout sits in calibration word bits 23 to 14.
// R15: level-wait sits in calibration word bits 13 to 9.
// R16: settle-count sits in calibration word bits 8 to 4.
// R17: an integer write with autocal set starts the three phases back to back.
//
// Design decisions made here: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none
module pcs_top (
   // clock and reset
   input  wire logic                      sys_clk,
   input  wire logic                      reset,
   // reference input pin
   input  wire logic                      reference_input,
   // register port
   input  wire logic [pcs_pkg::ADDR_W-1:0] reg_addr,
   input  wire logic [31:0]               reg_wdata,
   input  wire logic                      reg_write,
   input  wire logic                      reg_read,
   output logic      [31:0]               reg_rdata,
   // status
   output logic                           comparison_clock,
   output logic                           cal_busy,
   output logic                           cal_done,
   output logic [2:0]                     cal_phase
);
   localparam int CW = 24;   // phase counter width
   localparam int PCS_FW = pcs_pkg::PRIMARY_MOD_LOG2; // primary fraction width

   // timing notes for users of this block
   // - the reference pin is sampled by sys_clk, so it must stay below
   //   half of sys_clk or edges are lost in the synchroniser
   // - every phase counter moves only on cmp_en, so a slow reference
   //   stretches the whole calibration in proportion
   // - a zero product of two fields still gives one comparison cycle,
   //   so a blank field never stalls the sequencer in a phase
   // - a zero band divider acts as one, keeping the band clock defined
   // - a new autocal write restarts from the settle phase at once,
   //   whatever phase was running; the old counts are dropped
   // - the level-wait to settle-count ratio is the host's duty; the
   //   block does not check it, it only times what it is given
   // - field changes during a run take effect on the next compare,
   //   since the phase lengths are decoded from the live word
   // - addresses with any upper bit set hit nothing: writes are dropped
   //   and reads return zero

   // programmed values
   logic [pcs_pkg::INT_W-1:0]      int_value_q;
   logic [PCS_FW-1:0]              primary_fraction_q;
   logic [pcs_pkg::AUX_W-1:0]      auxiliary_fraction_q;
   logic [pcs_pkg::AUX_W-1:0]      auxiliary_modulus_q;
   logic [pcs_pkg::REFDIV_W-1:0]   ref_div_q;
   logic                           doubler_q;
   logic                           halve_q;
   logic [31:0]                    cal_word_q;

   // reference synchroniser and edge pulses
   logic ref_s1_q;
   logic ref_s2_q;
   logic ref_s3_q;
   logic ref_rise;
   logic ref_edge;
   logic ref_tick;
   logic [pcs_pkg::REFDIV_W-1:0] rdiv_cnt_q;
   logic rdiv_pulse;
   logic halve_q_t;
   logic cmp_en;

   // sequencer
   pcs_pkg::pcs_phase_t phase_q;
   logic [CW-1:0]  phase_cnt_q;
   logic [12:0]    band_cnt_q;
   logic [3:0]     band_periods_q;
   logic           start_cal;

   // register port decode
   logic           wr_hit;
   logic           rd_hit;
   logic [31:0]    rdata_d;

   // calibration fields
   logic [pcs_pkg::BAND_DIV_W-1:0] band_div;
   logic [pcs_pkg::TIMEOUT_W-1:0]  timeout_val;
   logic [pcs_pkg::WAIT5_W-1:0]    level_wait_value;
   logic [pcs_pkg::WAIT5_W-1:0]    settle_count;
   logic [CW-1:0] settle_len;
   logic [CW-1:0] level_len;
   logic [12:0]   band_len;

   // product of two fields clamped to at least one cycle
   function automatic logic [CW-1:0] pcs_len(input logic [CW-1:0] a,
                                            input logic [CW-1:0] b);
      logic [2*CW-1:0] p;
      p = a * b;
      pcs_len = (p[CW-1:0] == '0) ? CW'(1) : p[CW-1:0];
   endfunction : pcs_len

   // true when the upper address bits select this block's register page
   function automatic logic pcs_in_map(
      input logic [pcs_pkg::ADDR_W-1:0] a);
      pcs_in_map = (a[pcs_pkg::ADDR_W-1:4] == '0);
   endfunction : pcs_in_map

   // field extraction of the calibration word
   assign band_div         = cal_word_q[pcs_pkg::BAND_DIV_LSB +: pcs_pkg::BAND_DIV_W]; // R13
   assign timeout_val      = cal_word_q[pcs_pkg::TIMEOUT_LSB +: pcs_pkg::TIMEOUT_W]; // R14
   assign level_wait_value = cal_word_q[pcs_pkg::LEVEL_LSB +: pcs_pkg::WAIT5_W]; // R15 R10
   assign settle_count     = cal_word_q[pcs_pkg::SETTLE_LSB +: pcs_pkg::WAIT5_W]; // R16 R10

   // phase lengths in comparison cycles
   assign settle_len = pcs_len(CW'(timeout_val), CW'(settle_count)); // R5
   assign level_len  = pcs_len(CW'(pcs_pkg::LEVEL_MULT) * CW'(level_wait_value),
                               CW'(timeout_val)); // R9
   assign band_len   = (band_div == '0) ? 13'(pcs_pkg::BAND_PRESCALE)
                     : 13'(band_div) * 13'(pcs_pkg::BAND_PRESCALE); // R7

   // strobes qualified by the register page; both use one decode
   assign wr_hit = reg_write && pcs_in_map(reg_addr);
   assign rd_hit = reg_read && pcs_in_map(reg_addr);

   // register writes
   // the calibration word keeps only its field bits, the low control
   // nibble always reads back as zero
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         int_value_q          <= '0;
         primary_fraction_q   <= '0;
         auxiliary_fraction_q <= '0;
         auxiliary_modulus_q  <= pcs_pkg::AUX_MOD_RESET;
         ref_div_q            <= pcs_pkg::REFDIV_RESET;
         doubler_q            <= 1'b0;
         halve_q              <= 1'b0;
         cal_word_q           <= pcs_pkg::CAL_RESET;
      end else if (wr_hit) begin
         unique case (reg_addr[3:0])
            pcs_pkg::REG_INT_IDX:   int_value_q <= reg_wdata[pcs_pkg::INT_W-1:0];
            pcs_pkg::REG_PRIMARY_FRACTION_IDX: primary_fraction_q <= reg_wdata[PCS_FW-1:0];
            pcs_pkg::REG_AUX_IDX: begin
               auxiliary_fraction_q <=
                  reg_wdata[pcs_pkg::AUX_FRAC_LSB +: pcs_pkg::AUX_W];
               auxiliary_modulus_q <=
                  reg_wdata[pcs_pkg::AUX_MOD_LSB +: pcs_pkg::AUX_W];
            end
            pcs_pkg::REG_REF_IDX: begin
               ref_div_q <= reg_wdata[pcs_pkg::REFDIV_W-1:0];
               doubler_q <= reg_wdata[pcs_pkg::DOUBLE_BIT];
               halve_q   <= reg_wdata[pcs_pkg::HALVE_BIT];
            end
            pcs_pkg::REG_CAL_IDX: begin
               cal_word_q <= {reg_wdata[31:pcs_pkg::SETTLE_LSB],
                              pcs_pkg::SETTLE_LSB'(0)}; // R13 R14 R15 R16
            end
            default: ;
         endcase
      end
   end

   // autocal start on an integer write
   // the autocal bit is a trigger only, it is never stored
   assign start_cal = wr_hit && (reg_addr[3:0] == pcs_pkg::REG_INT_IDX)
                      && reg_wdata[pcs_pkg::AUTOCAL_BIT]; // R17

   // reference pin synchroniser
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         ref_s1_q <= 1'b0;
         ref_s2_q <= 1'b0;
         ref_s3_q <= 1'b0;
      end else begin
         ref_s1_q <= reference_input;
         ref_s2_q <= ref_s1_q;
         ref_s3_q <= ref_s2_q;
      end
   end

   // doubler uses both edges, otherwise rising only
   assign ref_rise = ref_s2_q & ~ref_s3_q;
   assign ref_edge = ref_s2_q ^ ref_s3_q;
   assign ref_tick = doubler_q ? ref_edge : ref_rise; // R2

   // reference divider
   // a divider value of zero behaves as one: the compare below is
   // then true on every tick, so no reference edge is ever swallowed
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         rdiv_cnt_q <= '0;
      end else if (ref_tick) begin
         if (rdiv_cnt_q + 10'h001 >= ref_div_q) begin
            rdiv_cnt_q <= '0;
         end else begin
            rdiv_cnt_q <= rdiv_cnt_q + 10'h001;
         end
      end
   end
   assign rdiv_pulse = ref_tick && (rdiv_cnt_q + 10'h001 >= ref_div_q); // R2

   // halve stage toggle gives an even duty cycle
   // enable only on every second divider pulse, so the comparison
   // rate halves while the toggle keeps high and low equally long
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         halve_q_t <= 1'b0;
      end else if (rdiv_pulse) begin
         halve_q_t <= ~halve_q_t; // R3
      end
   end
   assign cmp_en = halve_q ? (rdiv_pulse & halve_q_t) : rdiv_pulse; // R2 R4

   // comparison clock level for observation
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         comparison_clock <= 1'b0;
      end else if (halve_q) begin
         comparison_clock <= halve_q_t; // R3
      end else if (cmp_en) begin
         comparison_clock <= ~comparison_clock;
      end
   end

   // phase sequencer
   // settle, band and level run back to back; each phase counts
   // comparison enables only, and a start write wins over any count
   // band selection nests a period counter inside a cycle counter so
   // the eleven band clock periods are counted exactly
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         phase_q        <= pcs_pkg::PCS_IDLE;
         phase_cnt_q    <= '0;
         band_cnt_q     <= '0;
         band_periods_q <= '0;
      end else if (start_cal) begin
         phase_q        <= pcs_pkg::PCS_SETTLE; // R17
         phase_cnt_q    <= '0;
         band_cnt_q     <= '0;
         band_periods_q <= '0;
      end else if (cmp_en) begin // R4
         unique case (phase_q)
            pcs_pkg::PCS_IDLE, pcs_pkg::PCS_LOCKED: ;
            pcs_pkg::PCS_SETTLE: begin
               if (phase_cnt_q + CW'(1) >= settle_len) begin
                  phase_q     <= pcs_pkg::PCS_BAND; // R6
                  phase_cnt_q <= '0;
               end else begin
                  phase_cnt_q <= phase_cnt_q + CW'(1); // R5
               end
            end
            pcs_pkg::PCS_BAND: begin
               if (band_cnt_q + 13'h0001 >= band_len) begin
                  band_cnt_q <= '0;
                  if (band_periods_q + 4'h1 >= 4'(pcs_pkg::BAND_PERIODS)) begin
                     phase_q        <= pcs_pkg::PCS_LEVEL; // R8
                     band_periods_q <= '0;
                  end else begin
                     band_periods_q <= band_periods_q + 4'h1;
                  end
               end else begin
                  band_cnt_q <= band_cnt_q + 13'h0001; // R7
               end
            end
            pcs_pkg::PCS_LEVEL: begin
               if (phase_cnt_q + CW'(1) >= level_len) begin
                  phase_q     <= pcs_pkg::PCS_LOCKED; // R17 R12
                  phase_cnt_q <= '0;
               end else begin
                  phase_cnt_q <= phase_cnt_q + CW'(1); // R9
               end
            end
         endcase
      end
   end

   // status outputs
   // busy covers all three timed phases, done is the locked state only
   assign cal_busy  = (phase_q == pcs_pkg::PCS_SETTLE)
                   || (phase_q == pcs_pkg::PCS_BAND)
                   || (phase_q == pcs_pkg::PCS_LEVEL); // R12
   assign cal_done  = (phase_q == pcs_pkg::PCS_LOCKED);
   assign cal_phase = phase_q;

   // read multiplexer, unmapped indices and pages read as zero
   // the ratio view truncates the fraction to its upper sixteen bits
   always_comb begin
      rdata_d = '0;
      if (rd_hit) begin
         unique case (reg_addr[3:0])
            pcs_pkg::REG_INT_IDX: begin
               rdata_d = 32'(int_value_q);
            end
            pcs_pkg::REG_PRIMARY_FRACTION_IDX: begin
               rdata_d = 32'(primary_fraction_q);
            end
            pcs_pkg::REG_AUX_IDX: begin
               rdata_d = {2'h0, auxiliary_modulus_q,
                          2'h0, auxiliary_fraction_q};
            end
            pcs_pkg::REG_REF_IDX: begin
               rdata_d = {14'h0000, halve_q, doubler_q, 6'h00, ref_div_q};
            end
            pcs_pkg::REG_CAL_IDX: begin
               rdata_d = cal_word_q;
            end
            pcs_pkg::REG_STAT_IDX: begin
               rdata_d = {27'h0000000, cal_done, cal_busy, phase_q};
            end
            // integer part of the feedback ratio, fraction in the rest
            pcs_pkg::REG_RATIO_IDX: begin
               rdata_d = {int_value_q,
                          primary_fraction_q[PCS_FW-1 -: 16]}; // R1
            end
            default: rdata_d = '0;
         endcase
      end
   end

   // register read, data one cycle after the strobe, held otherwise
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         reg_rdata <= '0;
      end else if (reg_read) begin
         reg_rdata <= rdata_d;
      end
   end
endmodule : pcs_top
`default_nettype wire

/* File: bench/pcs_top_assertions.sv */
// port checker of the calibration sequencer
`timescale 1ns/1ps
`default_nettype none
module pcs_assertions (
   // clock and reset
   input wire logic                        sys_clk,
   input wire logic                        reset,
   // register port
   input wire logic [pcs_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [31:0]                reg_wdata,
   input wire logic                       reg_write,
   input wire logic                       reg_read,
   input wire logic [31:0]                reg_rdata,
   // status
   input wire logic                       cal_busy,
   input wire logic                       cal_done,
   input wire logic [2:0]                 cal_phase
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   // phase steps
   sequence s_to_band;
      cal_phase == 3'h1 ##1 cal_phase == 3'h2;
   endsequence
   sequence s_start;
      reg_write && reg_addr == 8'h00 && reg_wdata[pcs_pkg::AUTOCAL_BIT];
   endsequence
   // properties
   property p_start; s_start |=> cal_phase == 3'h1; endproperty
   property p_busy; cal_busy == (cal_phase inside {3'h1, 3'h2, 3'h3});
   endproperty
   property p_done; cal_done == (cal_phase == 3'h4); endproperty
   property p_band_from;
      $changed(cal_phase) && cal_phase == 3'h2 |-> $past(cal_phase) == 3'h1;
   endproperty
   property p_level_from;
      $changed(cal_phase) && cal_phase == 3'h3 |-> $past(cal_phase) == 3'h2;
   endproperty
   property p_lock_from;
      $changed(cal_phase) && cal_phase == 3'h4 |-> $past(cal_phase) == 3'h3;
   endproperty
   property p_band_hold; s_to_band |-> (cal_phase == 3'h2) [*8]; endproperty
   property p_cal_read;
      reg_read && reg_addr == 8'h04 |=> reg_rdata[3:0] == 4'h0;
   endproperty
   property p_stat_read;
      reg_read && reg_addr == 8'h05 |=> reg_rdata[4:0] ==
         {$past(cal_done), $past(cal_busy), $past(cal_phase)};
   endproperty
   a_start: assert property (p_start) else $error("no settle start");
   a_busy: assert property (p_busy) else $error("busy wrong");
   a_done: assert property (p_done) else $error("done wrong");
   a_band_from: assert property (p_band_from) else $error("band early");
   a_level_from: assert property (p_level_from) else $error("level early");
   a_lock_from: assert property (p_lock_from) else $error("lock early");
   a_band_hold: assert property (p_band_hold) else $error("band short");
   a_cal_read: assert property (p_cal_read) else $error("cal low bits");
   a_stat_read: assert property (p_stat_read) else $error("status bad");
endmodule : pcs_assertions
bind pcs_top pcs_assertions i_chk (.sys_clk(sys_clk), .reset(reset),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
   .reg_read(reg_read), .reg_rdata(reg_rdata), .cal_busy(cal_busy),
   .cal_done(cal_done), .cal_phase(cal_phase));
`default_nettype wire

/* File: bench/pcs_host_model.sv */
// host model: register master and free running reference source
`timescale 1ns/1ps
`default_nettype none
module pcs_host_model #(parameter int REF_HALF_NS = 20) (
   // clock
   input  wire logic                        sys_clk,
   // register port
   output logic [pcs_pkg::ADDR_W-1:0]      reg_addr,
   output logic [31:0]                     reg_wdata,
   output logic                            reg_write,
   output logic                            reg_read,
   input  wire logic [31:0]                reg_rdata,
   // reference pin
   output logic                            reference_input
);
   // idle bus at time zero
   initial begin
      reg_addr = '0;
      reg_wdata = '0;
      reg_write = 1'b0;
      reg_read = 1'b0;
      reference_input = 1'b0;
   end
   // reference oscillator runs free
   always #(REF_HALF_NS) reference_input = ~reference_input;
   // one cycle write
   task wr(input logic [pcs_pkg::ADDR_W-1:0] a, input logic [31:0] v);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_write <= 1'b1;
      @(posedge sys_clk);
      reg_write <= 1'b0;
   endtask : wr
   // one cycle read, data taken the cycle after
   task rd(input logic [pcs_pkg::ADDR_W-1:0] a, output logic [31:0] v);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge sys_clk);
      reg_read <= 1'b0;
      #1 v = reg_rdata;
   endtask : rd
endmodule : pcs_host_model
`default_nettype wire

/* File: bench/pcs_top_tb_top.sv */
// self-checking bench of the calibration sequencer
`timescale 1ns/1ps
`default_nettype none
module pcs_top_tb_top;
   logic                       sys_clk = 1'b0;
   logic                       reset = 1'b1;
   logic [pcs_pkg::ADDR_W-1:0] reg_addr;
   logic [31:0]                reg_wdata, reg_rdata, rs, w, v;
   logic                       reg_write, reg_read, reference_input;
   logic                       comparison_clock, cal_busy, cal_done;
   logic [2:0]                 cal_phase;
   int                         err_count = 0;
   int                         compares = 0;
   // refdiv double halve banddiv timeout settle wait; wait 2.5x settle
   int tb[3][7] = '{'{1,0,0,1,2,2,5}, '{3,0,1,1,1,2,5}, '{2,1,0,2,3,2,5}};
   // 4 ns clock
   always #2 sys_clk = ~sys_clk;
   pcs_top i_dut (.sys_clk(sys_clk), .reset(reset),
      .reference_input(reference_input), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .comparison_clock(comparison_clock),
      .cal_busy(cal_busy), .cal_done(cal_done), .cal_phase(cal_phase));
   pcs_host_model i_host (.sys_clk(sys_clk), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .reference_input(reference_input));
   function logic [31:0] xs();
      rs ^= rs << 13;
      rs ^= rs >> 17;
      rs ^= rs << 5;
      return rs;
   endfunction : xs
   task chk(string n, int e, int s, int t);
      compares++;
      if (s > e + t || s < e - t) begin
         err_count++;
         $display("BAD %s exp %0d got %0d", n, e, s);
      end
   endtask : chk
   task rdc(string n, logic [7:0] a, logic [31:0] e);
      i_host.rd(a, v);
      compares++;
      if (v !== e) begin
         err_count++;
         $display("BAD %s exp %h got %h", n, e, v);
      end
   endtask : rdc
   task test_done;
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : test_done
   // one calibration run measured against the phase model
   task run_cal(int i);
      int cmp, n, m, tot;
      int e[4];
      cmp = tb[i][0] * 10 * (1 + tb[i][2]) / (1 + tb[i][1]);
      e[1] = tb[i][4] * tb[i][5] * cmp;
      e[2] = pcs_pkg::BAND_PRESCALE * pcs_pkg::BAND_PERIODS * tb[i][3] * cmp;
      e[3] = pcs_pkg::LEVEL_MULT * tb[i][6] * tb[i][4] * cmp;
      i_host.wr(8'h03, 32'(tb[i][0] | tb[i][1] << 16 | tb[i][2] << 17));
      i_host.wr(8'h04, 32'(tb[i][3] << 24 | tb[i][4] << 14 | tb[i][6] << 9
         | tb[i][5] << 4));
      i_host.wr(8'h00, 32'h0020_0044);
      #1 chk("start", 1, (cal_phase === 3'h1) ? 1 : 0, 0);
      tot = 0;
      for (int p = 1; p < 4; p++) begin
         n = 0;
         while (cal_phase === 3'(p) && n < 2 * e[p] + 200) begin
            @(posedge sys_clk);
            #1 n++;
         end
         chk("phase time", e[p], n, cmp + 4);
         tot += n;
      end
      chk("total", e[1] + e[2] + e[3], tot, 3 * cmp + 12);
      rdc("status", 8'h05, 32'h0000_0014);
      if (tb[i][2] != 0) begin
         wait (comparison_clock === 1'b0);
         wait (comparison_clock === 1'b1);
         n = 0;
         m = 0;
         while (comparison_clock === 1'b1 && n < 999) @(posedge sys_clk) n++;
         while (comparison_clock === 1'b0 && m < 999) @(posedge sys_clk) m++;
         chk("duty", n, m, 1);
      end
      $display("calibration test %0d done", i);
   endtask : run_cal
   // main sequence
   initial begin
      rs = 32'h0000_005C;
      repeat (4) @(posedge sys_clk);
      reset <= 1'b0;
      rdc("aux reset", 8'h02, 32'h0001_0000);
      rdc("ref reset", 8'h03, 32'h0000_0001);
      rdc("cal reset", 8'h04, 32'h0000_0000);
      i_host.wr(8'h07, xs());
      rdc("unmapped", 8'h07, 32'h0000_0000);
      w = xs();
      i_host.wr(8'h04, w);
      rdc("cal word", 8'h04, w & 32'hFFFF_FFF0);
      w = xs() & 32'hFFDF_FFFF;
      v = xs();
      i_host.wr(8'h00, w);
      i_host.wr(8'h01, v);
      rdc("ratio", 8'h06, {w[15:0], v[23:8]});
      w = xs();
      i_host.wr(8'h02, w);
      rdc("aux word", 8'h02, w & 32'h3FFF_3FFF);
      $display("register test done");
      for (int i = 0; i < 3; i++) run_cal(i);
      test_done;
   end
   // watchdog against a hang
   initial begin
      #300000;
      err_count++;
      $display("BAD watchdog exp done got hang");
      test_done;
   end
endmodule : pcs_top_tb_top
`default_nettype wire
